// *** oss_switch_ctrl.sv ***
`timescale 1ns/10ps
`include "oss_defs.svh"
// What this block does
// - data moves only while chip select low
// - chip select rise latches shift register
// - chip select fall loads drain status
// - status driver enabled only while selected
// - clock and data ignored while deselected
// - command bit sampled on clock fall
// - status output shifts on clock rise
// - one means off, zero means on
// - eight bits, first bit is output 7
// - shift register holds exactly eight bits
// - status one off, zero on
// - status msb first, reports previous command
// - status pin ignores hardware reset
// - reset clears register, all outputs off
// - strap selects latch-off or current limit
// - over-voltage forces off, status all ones
// - thermal recovery waits for new command
module oss_switch_ctrl (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic csPin_n,
    input wire logic sclkPin,
    input wire logic sdiPin,
    output logic sdoOut,
    output logic sdoOe,
    input wire logic short_latch_disable,
    input wire logic [7:0] drainHigh,
    input wire logic [7:0] overCurrent,
    input wire logic [7:0] overTemp,
    input wire logic overVoltage,
    output logic [7:0] gateOn,
    output logic [7:0] currentLimit
);
    oss_link_if link ();
    logic [7:0] shiftReg;
    logic [7:0] cmdLatch;
    logic [7:0] faultOff;
    logic strapSync;
    logic strapMeta1;
    logic [7:0] ocSync;
    logic [7:0] ocMeta;
    logic [7:0] otSync;
    logic [7:0] otMeta;
    logic [7:0] dhSync;
    logic [7:0] dhMeta;
    logic ovSync;
    logic ovMeta;
    logic ovSeen;
    logic sdoBit;
    logic sdoEn;
    logic [`OSS_CNT_W-1:0] bitCnt;
    logic [7:0] statusNow;

    // *****************************************************************
    // status word
    // *****************************************************************
    // an over-voltage trip reads all off for one frame, then drains
    function automatic logic [7:0] status_word(
        input logic ov,
        input logic [7:0] drain
    );
        return ov ? `OSS_ALL_OFF : drain;
    endfunction : status_word
    assign statusNow = status_word(ovSeen, dhSync);

    // *****************************************************************
    // pin capture
    // *****************************************************************
    oss_pin_sync u_sync (
        .mclk(mclk),
        .rst_n(rst_n),
        .csPin_n(csPin_n),
        .sclkPin(sclkPin),
        .sdiPin(sdiPin),
        .link(link)
    );

    // analog fault flags are asynchronous, so two flops each
    always_ff @(posedge mclk) begin
        ocMeta <= overCurrent;
        ocSync <= ocMeta;
        otMeta <= overTemp;
        otSync <= otMeta;
        dhMeta <= drainHigh;
        dhSync <= dhMeta;
        ovMeta <= overVoltage;
        ovSync <= ovMeta;
        strapMeta1 <= short_latch_disable;
        strapSync <= strapMeta1;
    end
    // *****************************************************************
    // shift register
    // *****************************************************************
    // status load on select fall, shift in on clock fall; ignored when
    // deselected. the msb leaves on sdo so long frames chain through
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shiftReg <= 8'h00;
        end else if (link.evt.csFall) begin
            // an over-voltage trip reports all off once
            shiftReg <= statusNow;
        end else if (link.evt.csLow && link.evt.sclkFall) begin
            shiftReg <= {shiftReg[6:0], link.sdi};
        end
    end

    // bits seen this frame; saturates, register stays eight wide
    always_ff @(posedge mclk) begin
        if (!rst_n || link.evt.csFall) begin
            bitCnt <= '0;
        end else if (link.evt.csLow && link.evt.sclkFall
                && bitCnt != `OSS_CNT_W'(`OSS_NCH)) begin
            bitCnt <= bitCnt + 1'b1;
        end
    end

    // *****************************************************************
    // status output, kept off the hardware reset on purpose
    // *****************************************************************
    // the msb is presented at select fall and again at the first clock
    // rise; each later rise shows the bit that the prior fall moved up
    always_ff @(posedge mclk) begin
        if (link.evt.csFall) begin
            sdoBit <= statusNow[7];
        end else if (link.evt.csLow && link.evt.sclkRise) begin
            sdoBit <= shiftReg[7];
        end
    end

    // driver follows select only, never reset
    always_ff @(posedge mclk) begin
        sdoEn <= link.evt.csLow;
    end
    assign sdoOut = sdoBit;
    assign sdoOe = sdoEn;

    // *****************************************************************
    // output latch
    // *****************************************************************
    // a one in the latch means off; last eight bits in are taken
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cmdLatch <= `OSS_ALL_OFF;
        end else if (ovSync) begin
            cmdLatch <= `OSS_ALL_OFF;
        end else if (link.evt.csRise) begin
            cmdLatch <= shiftReg;
        end
    end

    // over-voltage memory, cleared once reported at the next frame
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ovSeen <= 1'b0;
        end else if (ovSync) begin
            ovSeen <= 1'b1; // set wins over clear
        end else if (link.evt.csRise) begin
            ovSeen <= 1'b0;
        end
    end

    // per-channel latched shutdown; a new write releases it so
    // recovery needs the next command to ask for on again
    genvar ch;
    generate
        for (ch = 0; ch < `OSS_NCH; ch++) begin : g_ch
            always_ff @(posedge mclk) begin
                if (!rst_n) begin
                    faultOff[ch] <= 1'b0;
                end else if (otSync[ch]
                        || (ocSync[ch] && !strapSync)) begin
                    faultOff[ch] <= 1'b1;
                end else if (link.evt.csRise) begin
                    faultOff[ch] <= 1'b0;
                end
            end
            assign gateOn[ch] = !cmdLatch[ch] && !faultOff[ch];
            // strap high keeps a shorted output on, limited
            assign currentLimit[ch] = gateOn[ch] && ocSync[ch]
                && strapSync;
        end
    endgenerate

    // *****************************************************************
    // checks
    // *****************************************************************
    property p_latch;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csRise && !ovSync |=> cmdLatch == $past(shiftReg);
    endproperty
    a_latch: assert property (p_latch) else $error("latch miss");

    property p_oe;
        @(posedge mclk) link.evt.csLow |=> sdoOe;
    endproperty
    a_oe: assert property (p_oe) else $error("sdo not on");

    property p_oeoff;
        @(posedge mclk) !link.evt.csLow |=> !sdoOe;
    endproperty
    a_oeoff: assert property (p_oeoff) else $error("sdo on");

    property p_load;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csFall && !ovSeen |=> shiftReg == $past(dhSync);
    endproperty
    a_load: assert property (p_load) else $error("no load");

    property p_ignore;
        @(posedge mclk) disable iff (!rst_n)
        !link.evt.csLow && !link.evt.csFall |=> $stable(shiftReg);
    endproperty
    a_ignore: assert property (p_ignore) else $error("deselect");

    property p_shift;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csLow && link.evt.sclkFall && !link.evt.csFall
        |=> shiftReg == {$past(shiftReg[6:0]), $past(link.sdi)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift");

    property p_sdo;
        @(posedge mclk) link.evt.csLow && link.evt.sclkRise
        && !link.evt.csFall |=> sdoOut == $past(shiftReg[7]);
    endproperty
    a_sdo: assert property (p_sdo) else $error("sdo bit");

    property p_rst;
        @(posedge mclk) !rst_n |=> gateOn == 8'h00 && shiftReg == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("reset");

    property p_ov;
        @(posedge mclk) disable iff (!rst_n)
        ovSync |=> gateOn == 8'h00;
    endproperty
    a_ov: assert property (p_ov) else $error("ov on");

    property p_short;
        @(posedge mclk) disable iff (!rst_n)
        ocSync != 8'h00 && !strapSync
        |=> (gateOn & $past(ocSync)) == 8'h00;
    endproperty
    a_short: assert property (p_short) else $error("short");

    // *****************************************************************
    // further checks, mostly on the fault and frame paths
    // *****************************************************************
    // a count past eight would mean the frame length rule slipped
    property p_count;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csLow && link.evt.sclkFall && !link.evt.csFall
        && bitCnt < `OSS_CNT_W'(`OSS_NCH)
        |=> bitCnt == $past(bitCnt) + 4'h1;
    endproperty
    a_count: assert property (p_count) else $error("count");

    property p_first;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csFall && !ovSeen |=> sdoOut == $past(dhSync[7]);
    endproperty
    a_first: assert property (p_first) else $error("first bit");

    property p_ovst;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csFall && ovSeen
        |=> (shiftReg == `OSS_ALL_OFF) && sdoOut;
    endproperty
    a_ovst: assert property (p_ovst) else $error("ov status");

    // latch moves only at select rise or an over-voltage trip
    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        !link.evt.csRise && !ovSync |=> $stable(cmdLatch);
    endproperty
    a_hold: assert property (p_hold) else $error("latch moved");

    property p_ot;
        @(posedge mclk) disable iff (!rst_n)
        otSync != 8'h00 |=> (gateOn & $past(otSync)) == 8'h00;
    endproperty
    a_ot: assert property (p_ot) else $error("hot on");

    // clean latch: every output follows the command just taken
    property p_rearm;
        @(posedge mclk) disable iff (!rst_n)
        link.evt.csRise && !ovSync && otSync == 8'h00
        && ocSync == 8'h00 |=> gateOn == ~$past(shiftReg);
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearm");

    // strap high: a shorted output keeps its state, limited
    property p_limit;
        @(posedge mclk) disable iff (!rst_n)
        strapSync && ocSync != 8'h00 && otSync == 8'h00
        && !ovSync && !link.evt.csRise |=> $stable(gateOn);
    endproperty
    a_limit: assert property (p_limit) else $error("limit");

    property p_rstlim;
        @(posedge mclk) !rst_n |=> currentLimit == 8'h00;
    endproperty
    a_rstlim: assert property (p_rstlim) else $error("limit rst");
endmodule : oss_switch_ctrl

// *** oss_defs.svh ***
`ifndef OSS_DEFS_SVH
`define OSS_DEFS_SVH

// *****************************************************************
// frame layout
// *****************************************************************
`define OSS_NCH 8
`define OSS_ALL_OFF 8'hff
`define OSS_CNT_W 4

// *****************************************************************
// timing
// *****************************************************************
`define OSS_MCLK_NS 5
`define OSS_RST_MIN_NS 250
// least reset hold in mclk cycles, rounded up
`define OSS_RST_MIN_CYC ((`OSS_RST_MIN_NS + `OSS_MCLK_NS - 1) / `OSS_MCLK_NS)

`endif

// *** oss_pkg.sv ***
package oss_pkg;
    // events seen on the sampled link pins
    typedef struct packed {
        logic csFall;
        logic csRise;
        logic sclkFall;
        logic sclkRise;
        logic csLow;
    } oss_evt_t;
endpackage : oss_pkg

// *** oss_link_if.sv ***
`timescale 1ns/10ps
interface oss_link_if;
    oss_pkg::oss_evt_t evt;
    logic sdi;
    modport sync (output evt, output sdi);
    modport core (input evt, input sdi);
endinterface : oss_link_if

// *** oss_pin_sync.sv ***
`timescale 1ns/10ps
`include "oss_defs.svh"
// *****************************************************************
// two-flop synchroniser and edge finder for the link pins
// *****************************************************************
module oss_pin_sync (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic csPin_n,
    input wire logic sclkPin,
    input wire logic sdiPin,
    oss_link_if.sync link
);
    logic csMeta_n;
    logic csSync_n;
    logic csOld_n;
    logic [1:0] meta;
    logic [1:0] sync;
    logic sclkOld;

    // select path runs free: the status driver must not see reset,
    // and a reset in mid-frame must not fake a select edge
    always_ff @(posedge mclk) begin
        csMeta_n <= csPin_n;
        csSync_n <= csMeta_n;
        csOld_n <= csSync_n;
    end

    // clock and data; first stage feeds only the second, and the
    // reset level matches the parked-low clock so no false edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= 2'h0;
            sync <= 2'h0;
            sclkOld <= 1'b0;
        end else begin
            meta <= {sdiPin, sclkPin};
            sync <= meta;
            sclkOld <= sync[0];
        end
    end

    // edge pulses, one mclk wide, then the select level and data
    assign link.evt.csFall = csOld_n & ~csSync_n;
    assign link.evt.csRise = ~csOld_n & csSync_n;
    assign link.evt.sclkRise = ~sclkOld & sync[0];
    assign link.evt.sclkFall = sclkOld & ~sync[0];
    assign link.evt.csLow = ~csSync_n;
    assign link.sdi = sync[1];
endmodule : oss_pin_sync

// *** oss_spi_master.sv ***
`timescale 1ns/10ps
// *****************************************************************
// spi master model on the far side of the link
// *****************************************************************
module oss_spi_master (
    input wire logic mclk,
    input wire logic sdoLine,
    output logic csPin_n,
    output logic sclkPin,
    output logic sdiPin
);
    // clock parked low while deselected
    initial begin
        csPin_n = 1'b1;
        sclkPin = 1'b0;
        sdiPin = 1'b0;
    end

    // 60 ns, the clock high phase of the 150 ns link period
    task automatic half;
        repeat (12) @(posedge mclk);
        #1;
    endtask : half

    // select edges only with the clock low
    task automatic sel(input logic lvl);
        half();
        csPin_n = lvl;
        half();
    endtask : sel

    // data set well after the fall, steady over the rise
    task automatic bitx(input logic b, output logic s);
        repeat (6) @(posedge mclk);
        #1;
        sdiPin = b;
        half();
        sclkPin = 1'b1;
        half();
        s = sdoLine;
        sclkPin = 1'b0;
    endtask : bitx
endmodule : oss_spi_master

// *** tb.sv ***
`timescale 1ns/10ps
`include "oss_defs.svh"
// *****************************************************************
// self-checking bench
// *****************************************************************
module tb;
    logic mclk = 1'b0;
    logic rst_n, strap, overVoltage;
    logic [7:0] overCurrent, overTemp;
    logic [7:0] drainHigh, gateOn, currentLimit, st;
    logic [15:0] s16;
    logic sdoOut, sdoOe, csPin_n, sclkPin, sdiPin, sdoLine;
    logic lastSdo = 1'b0;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // drains follow the switches, no open loads fitted
    assign drainHigh = ~gateOn;
    // released line shows the inverse, so a stale bit cannot pass
    assign sdoLine = sdoOe ? sdoOut : ~lastSdo;
    always @(posedge mclk) if (sdoOe) lastSdo <= sdoOut;

    oss_switch_ctrl uut (.mclk(mclk), .rst_n(rst_n), .csPin_n(csPin_n),
        .sclkPin(sclkPin), .sdiPin(sdiPin), .sdoOut(sdoOut), .sdoOe(sdoOe),
        .short_latch_disable(strap), .drainHigh(drainHigh),
        .overCurrent(overCurrent), .overTemp(overTemp),
        .overVoltage(overVoltage), .gateOn(gateOn),
        .currentLimit(currentLimit));
    oss_spi_master m (.mclk(mclk), .sdoLine(sdoLine), .csPin_n(csPin_n),
        .sclkPin(sclkPin), .sdiPin(sdiPin));

    task automatic report_and_stop;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : wt

    // one full 8-bit frame, then time for the latch to reach the gates
    task automatic frame8(input logic [7:0] cmd, output logic [7:0] s);
        m.sel(1'b0);
        for (int i = 7; i >= 0; i--) m.bitx(cmd[i], s[i]);
        m.sel(1'b1);
        wt(8);
    endtask : frame8

    // hang guard, a few frames need well under this
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // *****************************************************************
    // scenarios
    // *****************************************************************
    task automatic t_write;
        chk("gate rst", gateOn, 8'h00);
        chk("oe idle", {7'h0, sdoOe}, 8'h00);
        frame8(8'ha5, st);
        chk("st0", st, 8'hff);
        chk("gate1", gateOn, ~8'ha5);
        frame8(8'h3c, st);
        chk("st1", st, 8'ha5);
        chk("gate2", gateOn, ~8'h3c);
    endtask : t_write

    // clock and data wiggle with select high, nothing may move
    task automatic t_ignore;
        repeat (8) begin
            m.half();
            m.sclkPin = ~m.sclkPin;
            m.sdiPin = ~m.sclkPin;
        end
        wt(8);
        chk("gate ign", gateOn, ~8'h3c);
        chk("oe ign", {7'h0, sdoOe}, 8'h00);
    endtask : t_ignore

    // sixteen clocks: older byte falls out of the far end
    task automatic t_chain;
        logic [15:0] cmd16;
        cmd16 = 16'h0f81;
        m.sel(1'b0);
        for (int i = 15; i >= 0; i--) m.bitx(cmd16[i], s16[i]);
        m.sel(1'b1);
        wt(8);
        chk("chain st", s16[15:8], 8'h3c);
        chk("chain out", s16[7:0], 8'h0f);
        chk("chain gate", gateOn, ~8'h81);
    endtask : t_chain

    task automatic t_faults;
        overCurrent = 8'h02;
        wt(6);
        chk("short off", gateOn, 8'h7c);
        overCurrent = 8'h00;
        wt(6);
        chk("short held", gateOn, 8'h7c);
        frame8(8'h81, st);
        chk("short st", st, 8'h83);
        chk("short rearm", gateOn, 8'h7e);
        strap = 1'b1;
        overCurrent = 8'h02;
        wt(6);
        chk("limit on", gateOn, 8'h7e);
        chk("limit flag", currentLimit, 8'h02);
        overCurrent = 8'h00;
        strap = 1'b0;
        overVoltage = 1'b1;
        wt(6);
        chk("ov off", gateOn, 8'h00);
        overVoltage = 1'b0;
        wt(6);
        chk("ov held", gateOn, 8'h00);
        frame8(8'h81, st);
        chk("ov st", st, 8'hff);
        overTemp = 8'h02;
        wt(6);
        overTemp = 8'h00;
        wt(6);
        chk("ot held", gateOn, 8'h7c);
        frame8(8'h81, st);
        chk("ot back", gateOn, 8'h7e);
    endtask : t_faults

    // reset while selected: gates drop, status driver untouched
    task automatic t_rst_mid;
        m.sel(1'b0);
        rst_n = 1'b0;
        wt(`OSS_RST_MIN_CYC);
        chk("rst gate", gateOn, 8'h00);
        chk("rst oe", {7'h0, sdoOe}, 8'h01);
        rst_n = 1'b1;
        m.sel(1'b1);
        wt(8);
        chk("rst oe off", {7'h0, sdoOe}, 8'h00);
    endtask : t_rst_mid

    // power-up reset held 16 cycles before the first frame
    initial begin
        rst_n = 1'b0;
        strap = 1'b0;
        overVoltage = 1'b0;
        overCurrent = 8'h00;
        overTemp = 8'h00;
        wt(16);
        rst_n = 1'b1;
        wt(4);
        t_write();
        t_ignore();
        t_chain();
        t_faults();
        t_rst_mid();
        report_and_stop();
    end
endmodule : tb
